// [rtl/otg_event_flags.sv]
// otg event flags and enables with apb access and one level interrupt
// assumes pins are asynchronous, sleep_mode comes from the clk domain
//
// Behaviour
// - cable id pin change sets flag bit 7.
// - each expiry of the internal 1 ms timer sets flag bit 6.
// - line stable 1 ms and different from last settled state sets bit 5.
// - activity on any pin but se0 and j while in low power sets flag bit 4.
// - vbus dropping below session end level sets flag bit 3.
// - any transition on session end input sets flag bit 2.
// - any transition on session valid input sets flag bit 0.
// - flags set by hardware or the set and invert aliases, reset zero, write one clears, zero keeps.
// - bit 1 and bits 31:8 of both registers read zero, ignore writes.
// - enable bits 7 and 6 unmask id and millisecond events, reset zero.
// - enable bits 5 and 4 unmask line settled and bus activity.
// - enable bits 3, 2, 0 unmask vbus drop, session end change, session valid change.
// - clear, set, invert aliases at +0x4, +0x8, +0xc of each register.
// - line state is se0 with j state, settled only if both unchanged 1 ms.
`timescale 1ns/100ps
module otg_event_flags #(
   parameter int unsigned MS_CYCLES = otg_event_pkg::MS_CYCLES
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // cable and transceiver levels, asynchronous
   input  wire logic        cable_id,
   input  wire logic        session_valid_in,
   input  wire logic        session_end_in,
   input  wire logic        dp_level,
   input  wire logic        dm_level,
   input  wire logic        se0_indication,
   input  wire logic        j_line_state_indication,
   // power state
   input  wire logic        sleep_mode,
   // interrupt
   output logic             otg_irq
);

   logic [otg_event_pkg::PIN_W-1:0] pins_raw;
   logic [otg_event_pkg::PIN_W-1:0] pins_s;
   logic [4:0]                      prev_r;
   logic [1:0]                      line_prev_r;
   logic [1:0]                      settled_r;
   logic [7:0]                      flags_r;
   logic [7:0]                      flags_nxt;
   logic [7:0]                      enables_r;
   logic [7:0]                      enables_nxt;
   logic [7:0]                      ev;
   logic [7:0]                      prdata_r;
   logic                            pslverr_r;
   logic                            ms_tick;
   logic                            settle_tick;

   assign pins_raw = {j_line_state_indication, se0_indication, dm_level, dp_level,
                      session_end_in, session_valid_in, cable_id};

   pin_sync #(
      .W (otg_event_pkg::PIN_W)
   ) u_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .d     (pins_raw),
      .q     (pins_s)
   );

   // synchronised levels
   wire id_s  = pins_s[otg_event_pkg::PIN_ID];
   wire sv_s  = pins_s[otg_event_pkg::PIN_SVALID];
   wire se_s  = pins_s[otg_event_pkg::PIN_SEND];
   wire dp_s  = pins_s[otg_event_pkg::PIN_DP];
   wire dm_s  = pins_s[otg_event_pkg::PIN_DM];
   wire [1:0] line_s = {pins_s[otg_event_pkg::PIN_SE0], pins_s[otg_event_pkg::PIN_J]};

   // edge detection waits until the synchroniser and prev_r hold real levels,
   // else a pin resting high at reset release would look like an edge
   // limitation: a genuine pin edge inside those first cycles is not flagged
   logic [1:0] warm_r;
   wire        live = (warm_r == 2'h3);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         warm_r <= 2'h0;
      end else if (!live) begin
         warm_r <= warm_r + 2'h1;
      end
   end

   wire [4:0] cur = {dm_s, dp_s, se_s, sv_s, id_s};
   wire [4:0] chg = live ? (cur ^ prev_r) : 5'h00;
   wire line_chg = (line_s != line_prev_r);

   // millisecond timer runs free
   period_counter #(
      .COUNT (MS_CYCLES)
   ) u_ms (
      .clk     (clk),
      .rst_n   (rst_n),
      .restart (1'b0),
      .tick    (ms_tick)
   );

   // settle timer restarts on any change of se0 or j
   period_counter #(
      .COUNT (MS_CYCLES)
   ) u_settle (
      .clk     (clk),
      .rst_n   (rst_n),
      .restart (line_chg),
      .tick    (settle_tick)
   );

   wire settle_new = settle_tick && !line_chg && (line_s != settled_r);

   // hardware events, one cycle each
   always_comb begin
      ev = 8'h00;
      ev[otg_event_pkg::CABLE_ID_BIT]      = chg[0];
      ev[otg_event_pkg::MS_TICK_BIT]       = ms_tick;
      ev[otg_event_pkg::LINE_SETTLED_BIT]  = settle_new;
      ev[otg_event_pkg::BUS_ACTIVITY_BIT]  = sleep_mode && (|chg);
      ev[otg_event_pkg::SESSION_VALID_BIT] = chg[2] && se_s;
      ev[otg_event_pkg::SESSION_END_BIT]   = chg[2];
      ev[otg_event_pkg::A_VBUS_BIT]        = chg[1];
   end

   // apb decode; zero wait states, so pready is tied high
   wire       access    = psel && penable;
   wire       setup     = psel && !penable;
   wire       hit_flags = (paddr[7:4] == otg_event_pkg::FLAGS_OFFSET[7:4]);
   wire       hit_en    = (paddr[7:4] == otg_event_pkg::ENABLES_OFFSET[7:4]);
   wire       mapped    = (hit_flags || hit_en) && (paddr[1:0] == 2'h0);
   wire [1:0] alias_sel = paddr[3:2];
   wire [7:0] wd        = pwdata[7:0] & otg_event_pkg::IMPL_MASK;
   wire       wr_flags  = access && pwrite && mapped && hit_flags;
   wire       wr_en     = access && pwrite && mapped && hit_en;

   // base write: w1c for flags, plain store for enables
   function automatic logic [7:0] apply(input logic [7:0] old, input logic [7:0] d,
                                        input logic [1:0] sel, input logic w1c);
      logic [7:0] r;
      r = old;
      case (sel)
         otg_event_pkg::ALIAS_BASE: r = w1c ? (old & ~d) : d;
         otg_event_pkg::ALIAS_CLR:  r = old & ~d;
         otg_event_pkg::ALIAS_SET:  r = old | d;
         otg_event_pkg::ALIAS_INV:  r = old ^ d;
         default:                   r = old;
      endcase
      return r;
   endfunction

   // hardware set wins over a clear in the same cycle
   assign flags_nxt = ((wr_flags ? apply(flags_r, wd, alias_sel, 1'b1) : flags_r) | ev)
                      & otg_event_pkg::IMPL_MASK;
   assign enables_nxt = wr_en ? apply(enables_r, wd, alias_sel, 1'b0) : enables_r;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flags_r   <= otg_event_pkg::FLAGS_RESET;
         enables_r <= otg_event_pkg::ENABLES_RESET;
      end else begin
         flags_r   <= flags_nxt;
         enables_r <= enables_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prev_r      <= 5'h00;
         line_prev_r <= otg_event_pkg::LINE_RESET;
         settled_r   <= otg_event_pkg::LINE_RESET;
      end else begin
         prev_r      <= cur;
         line_prev_r <= line_s;
         if (settle_new) begin
            settled_r <= line_s;
         end
      end
   end

   // read data captured in setup so the access phase needs no wait
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prdata_r  <= 8'h00;
         pslverr_r <= 1'b0;
      end else if (setup) begin
         prdata_r  <= !mapped ? 8'h00 : (hit_flags ? flags_r : enables_r);
         pslverr_r <= !mapped;
      end
   end

   assign prdata  = {24'h000000, prdata_r};
   assign pready  = 1'b1;
   assign pslverr = pslverr_r && access;
   assign otg_irq = |(flags_r & enables_r);

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_id_flag;
      live && $changed(id_s) |=> flags_r[7];
   endproperty
   a_id_flag: assert property (p_id_flag) else $error("id change did not set flag");

   property p_ms_flag;
      ms_tick |=> flags_r[6];
   endproperty
   a_ms_flag: assert property (p_ms_flag) else $error("ms tick did not set flag");

   property p_settle;
      settle_tick && !line_chg && line_s != settled_r |=> flags_r[5] && settled_r == $past(line_s);
   endproperty
   a_settle: assert property (p_settle) else $error("settled line not flagged");

   property p_settle_restart;
      line_chg |=> ##1 !settle_tick;
   endproperty
   a_settle_restart: assert property (p_settle_restart) else $error("settle tick after change");

   property p_wake;
      live && sleep_mode && $changed(dp_s) |=> flags_r[4];
   endproperty
   a_wake: assert property (p_wake) else $error("activity in sleep not flagged");

   property p_sess_drop;
      live && $rose(se_s) |=> flags_r[3] && flags_r[2];
   endproperty
   a_sess_drop: assert property (p_sess_drop) else $error("session end rise not flagged");

   property p_send_chg;
      live && $changed(se_s) |=> flags_r[2];
   endproperty
   a_send_chg: assert property (p_send_chg) else $error("session end edge not flagged");

   property p_vbus_chg;
      live && $changed(sv_s) |=> flags_r[0];
   endproperty
   a_vbus_chg: assert property (p_vbus_chg) else $error("session valid change not flagged");

   property p_w1c;
      wr_flags && alias_sel == 2'h0 && pwdata[7] && !ev[7] |=> !flags_r[7];
   endproperty
   a_w1c: assert property (p_w1c) else $error("write one did not clear flag");

   property p_zero_keep;
      wr_flags && alias_sel == 2'h0 && !pwdata[0] && flags_r[0] |=> flags_r[0];
   endproperty
   a_zero_keep: assert property (p_zero_keep) else $error("zero write changed flag");

   property p_no_sw_set;
      !ev[5] && !(wr_flags && alias_sel[1]) && !flags_r[5] |=> !flags_r[5];
   endproperty
   a_no_sw_set: assert property (p_no_sw_set) else $error("flag set without cause");

   property p_unimpl;
      prdata[31:8] == 24'h000000 && !prdata[1] && !flags_r[1] && !enables_r[1];
   endproperty
   a_unimpl: assert property (p_unimpl) else $error("unimplemented bit nonzero");

   property p_en_write;
      wr_en && alias_sel == 2'h0 |=> enables_r == ($past(pwdata[7:0]) & 8'hfd);
   endproperty
   a_en_write: assert property (p_en_write) else $error("enable write not stored");

   property p_en_set;
      wr_en && alias_sel == 2'h2 |=>
         enables_r == ($past(enables_r) | ($past(pwdata[7:0]) & 8'hfd));
   endproperty
   a_en_set: assert property (p_en_set) else $error("set alias wrong");

   property p_en_clr;
      wr_en && alias_sel == 2'h1 |=>
         enables_r == ($past(enables_r) & ~$past(pwdata[7:0]));
   endproperty
   a_en_clr: assert property (p_en_clr) else $error("clear alias wrong");

   property p_en_inv;
      wr_en && alias_sel == 2'h3 |=>
         enables_r == ($past(enables_r) ^ ($past(pwdata[7:0]) & 8'hfd));
   endproperty
   a_en_inv: assert property (p_en_inv) else $error("invert alias wrong");

   property p_irq;
      otg_irq == ((flags_r & enables_r) != 8'h00);
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt level wrong");

   c_irq:    cover property ($rose(otg_irq));
   c_settle: cover property (ev[5] ##1 flags_r[5]);
   c_wake:   cover property (sleep_mode && ev[4]);
   c_clear:  cover property (wr_flags && ev != 8'h00);

endmodule

// [pkg/otg_event_pkg.sv]
// register map, field positions, reset values and timing for the otg event flags
// assumes a 100 MHz peripheral clock and a 32-bit apb register bus
package otg_event_pkg;

   // apb address space of the block
   localparam int unsigned ADDR_W = 8;
   localparam logic [7:0] FLAGS_OFFSET = 8'h00;
   localparam logic [7:0] ENABLES_OFFSET = 8'h10;

   // alias selected by address bits 3:2 above each register
   localparam logic [1:0] ALIAS_BASE = 2'h0;
   localparam logic [1:0] ALIAS_CLR = 2'h1;
   localparam logic [1:0] ALIAS_SET = 2'h2;
   localparam logic [1:0] ALIAS_INV = 2'h3;

   // bit positions shared by flags and enables
   localparam int unsigned CABLE_ID_BIT = 7;
   localparam int unsigned MS_TICK_BIT = 6;
   localparam int unsigned LINE_SETTLED_BIT = 5;
   localparam int unsigned BUS_ACTIVITY_BIT = 4;
   localparam int unsigned SESSION_VALID_BIT = 3;
   localparam int unsigned SESSION_END_BIT = 2;
   localparam int unsigned A_VBUS_BIT = 0;

   // implemented bits; bit 1 and 31:8 read zero
   localparam logic [7:0] IMPL_MASK = 8'hfd;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] ENABLES_RESET = 8'h00;
   localparam logic [1:0] LINE_RESET = 2'h0;

   // synchronised pin vector positions
   localparam int unsigned PIN_W = 7;
   localparam int unsigned PIN_ID = 0;
   localparam int unsigned PIN_SVALID = 1;
   localparam int unsigned PIN_SEND = 2;
   localparam int unsigned PIN_DP = 3;
   localparam int unsigned PIN_DM = 4;
   localparam int unsigned PIN_SE0 = 5;
   localparam int unsigned PIN_J = 6;

   // one millisecond in clock cycles
   localparam int unsigned CLK_MHZ = 100;
   localparam int unsigned MS_TIME_US = 1000;
   localparam int unsigned MS_CYCLES = MS_TIME_US * CLK_MHZ;

endpackage

// [rtl/pin_sync.sv]
// two-flop synchroniser for a vector of independent levels
// assumes each bit is a slow level, not a bus that must stay coherent
`timescale 1ns/100ps
module pin_sync #(
   parameter int unsigned W = 1
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule

// [rtl/period_counter.sv]
// free-running period counter with restart, one-cycle registered tick each period
// assumes COUNT of at least 1; restart holds the count at zero
`timescale 1ns/100ps
module period_counter #(
   parameter int unsigned COUNT = 100000
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // control and tick
   input  wire logic restart,
   output logic      tick
);
   localparam int unsigned W = $clog2(COUNT + 1);
   localparam logic [W-1:0] LAST = W'(COUNT - 1);

   logic [W-1:0] cnt_r;
   wire          at_last = (cnt_r == LAST);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cnt_r <= '0;
         tick  <= 1'b0;
      end else begin
         cnt_r <= (restart || at_last) ? '0 : cnt_r + W'(1);
         tick  <= at_last && !restart;
      end
   end
endmodule

// [verification/usb_cable_model.sv]
// behavioural cable side: id pin, vbus comparators and line levels
// assumes the bench moves want by non-blocking assignment just after a clk edge
`timescale 1ns/100ps
module usb_cable_model (
   // wanted levels, positions as the pin vector of the package
   input  wire logic [6:0] want,
   // cable and transceiver levels
   output logic            cable_id,
   output logic            session_valid_in,
   output logic            session_end_in,
   output logic            dp_level,
   output logic            dm_level,
   output logic            se0_indication,
   output logic            j_line_state_indication
);
   // whole-cycle levels only; sub-cycle glitches would be lost by the sync
   assign cable_id                = want[otg_event_pkg::PIN_ID];
   assign session_valid_in        = want[otg_event_pkg::PIN_SVALID];
   assign session_end_in          = want[otg_event_pkg::PIN_SEND];
   assign dp_level                = want[otg_event_pkg::PIN_DP];
   assign dm_level                = want[otg_event_pkg::PIN_DM];
   assign se0_indication          = want[otg_event_pkg::PIN_SE0];
   assign j_line_state_indication = want[otg_event_pkg::PIN_J];
endmodule

// [verification/otg_event_flags_tb_top.sv]
// apb-driven bench for the otg event flags with a cable model on the pins
// assumes zero or more apb wait states and a shortened millisecond count
`timescale 1ns/100ps
module otg_event_flags_tb_top;
   localparam int unsigned MS = 20;
   localparam logic [6:0] ev_want [7] = '{7'h01, 7'h03, 7'h07, 7'h03, 7'h0b, 7'h1b, 7'h1a};
   localparam logic [7:0] ev_flag [7] = '{8'h80, 8'h01, 8'h0c, 8'h04, 8'h10, 8'h00, 8'h90};
   localparam logic [6:0] ev_sleep = 7'b1010000;
   logic        clk;
   logic        rst_n;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        sleep_mode;
   logic        otg_irq;
   logic [6:0]  want;
   logic [31:0] rdata;
   logic        rerr;
   logic        id_w, sv_w, se_w, dp_w, dm_w, s0_w, j_w;
   int          bad_count;
   int          compares;

   usb_cable_model cable_u (.want(want), .cable_id(id_w), .session_valid_in(sv_w),
      .session_end_in(se_w), .dp_level(dp_w), .dm_level(dm_w), .se0_indication(s0_w),
      .j_line_state_indication(j_w));
   otg_event_flags #(.MS_CYCLES(MS)) dut_u (.clk(clk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .cable_id(id_w), .session_valid_in(sv_w),
      .session_end_in(se_w), .dp_level(dp_w), .dm_level(dm_w), .se0_indication(s0_w),
      .j_line_state_indication(j_w), .sleep_mode(sleep_mode), .otg_irq(otg_irq));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // one apb transfer; request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         bad_count++;
         wrap_up();
      end
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(n, rdata & m, e);
   endtask

   initial begin
      #500000;
      bad_count++;
      wrap_up();
   end

   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      sleep_mode = 1'b0;
      want = 7'h00;
      bad_count = 0;
      compares = 0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      // tick bit 6 runs free, so it is masked outside its own test
      rdc("flags reset", 8'h00, 32'hffffffbf, 32'h0);
      rdc("enables reset", 8'h10, 32'hffffffff, 32'h0);
      wr(8'h10, 32'hffffffff);
      rdc("enables all", 8'h10, 32'hffffffff, 32'hfd);
      wr(8'h14, 32'h0c);
      wr(8'h18, 32'h02);
      rdc("enables clr", 8'h10, 32'hffffffff, 32'hf1);
      wr(8'h18, 32'h04);
      wr(8'h1c, 32'h81);
      rdc("enables set inv", 8'h10, 32'hffffffff, 32'h74);
      wr(8'h10, 32'h0);
      for (int i = 0; i < 7; i++) begin
         @(posedge clk);
         want <= ev_want[i];
         sleep_mode <= ev_sleep[i];
         repeat (8) @(posedge clk);
         wr(8'h00, 32'h0);
         rdc("event flag", 8'h00, 32'h9f, {24'h0, ev_flag[i]});
         wr(8'h00, 32'h9f);
         rdc("event cleared", 8'h00, 32'hffffffbf, 32'h0);
      end
      wr(8'h08, 32'h01);
      wr(8'h0c, 32'h81);
      rdc("flags set inv", 8'h00, 32'h9f, 32'h80);
      wr(8'h04, 32'h80);
      rdc("flags clr", 8'h00, 32'h9f, 32'h0);
      want <= want | 7'h20;
      repeat (2 * MS + 5) @(posedge clk);
      rdc("line settled", 8'h00, 32'h20, 32'h20);
      wr(8'h00, 32'h20);
      repeat (2 * MS + 5) @(posedge clk);
      rdc("line same state", 8'h00, 32'h20, 32'h0);
      // toggles closer than the settle time must never count as settled
      repeat (3) begin
         want <= want ^ 7'h40;
         repeat (MS / 2) @(posedge clk);
      end
      rdc("line unsettled", 8'h00, 32'h20, 32'h0);
      repeat (2 * MS + 5) @(posedge clk);
      rdc("line new state", 8'h00, 32'h20, 32'h20);
      wr(8'h00, 32'h60);
      repeat (MS + 5) @(posedge clk);
      rdc("ms tick", 8'h00, 32'h40, 32'h40);
      wr(8'h00, 32'hff);
      want <= want ^ 7'h01;
      repeat (8) @(posedge clk);
      check("irq masked", {31'h0, otg_irq}, 32'h0);
      wr(8'h10, 32'h80);
      @(posedge clk);
      check("irq unmasked", {31'h0, otg_irq}, 32'h1);
      wr(8'h04, 32'h80);
      @(posedge clk);
      check("irq cleared", {31'h0, otg_irq}, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      check("unmapped err", {31'h0, rerr}, 32'h1);
      check("unmapped data", rdata, 32'h0);
      apb(1'b1, 8'h11, 32'hff);
      check("misaligned err", {31'h0, rerr}, 32'h1);
      rdc("misaligned ignored", 8'h10, 32'hffffffff, 32'h80);
      // mid-run reset with a flag and an enable set; pins parked low first
      want <= 7'h00;
      repeat (8) @(posedge clk);
      rdc("flags before reset", 8'h00, 32'h80, 32'h80);
      check("irq before reset", {31'h0, otg_irq}, 32'h1);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rdc("flags mid reset", 8'h00, 32'hffffffbf, 32'h0);
      rdc("enables mid reset", 8'h10, 32'hffffffff, 32'h0);
      check("irq after reset", {31'h0, otg_irq}, 32'h0);
      wrap_up();
   end
endmodule
